// *** dv/fcs_flash_ctrl_asserts.sv ***
`timescale 1ns/10ps
`include "fcs_defs.svh"
module fcs_flash_ctrl_asserts #(
  parameter logic [15:0] VERSION_WORD = 16'h0005
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [23:0] nv_addr,
  input wire logic nv_rd,
  input wire logic nv_dbl_fault,
  input wire logic arr_rd_req,
  input wire logic arr_dbl_fault,
  input wire logic arr_stall,
  input wire logic arr_data_invalid,
  input wire logic cmd_start
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Bus answers only in the slot after a read
  a_rdata_idle: assert property (reg_rdata != 8'h00 |-> $past(reg_rd)) else $error("stray read data");
  a_rsv_zero: assert property (reg_rd && reg_addr == `FCS_A_RSV |=> reg_rdata == 8'h00) else $error("rsv nonzero");
  a_ver_nibble: assert property (reg_rd && reg_addr == `FCS_A_VER |=> reg_rdata[3:0] == VERSION_WORD[3:0])
    else $error("bad version");
  // Launch is one pulse caused by a done-flag write
  a_start_pulse: assert property (cmd_start |=> !cmd_start) else $error("long start");
  a_start_cause: assert property (cmd_start |-> $past(reg_wr && reg_addr == `FCS_A_STAT && reg_wdata[7]))
    else $error("start without launch write");
  // Option byte fetched in the first cycle after reset
  a_nv_load: assert property ($past(reset) |-> nv_rd) else $error("no option load");
  a_nv_addr: assert property (nv_rd |-> nv_addr == `FCS_NV_OPT_ADDR) else $error("bad option address");
  a_inv_cause: assert property (arr_data_invalid |-> arr_dbl_fault && arr_rd_req && !arr_stall)
    else $error("invalid without fault");
  c_start: cover property (cmd_start);
  c_invalid: cover property (arr_data_invalid);
  c_load_fault: cover property (nv_rd && nv_dbl_fault);
endmodule
bind fcs_flash_ctrl fcs_flash_ctrl_asserts #(.VERSION_WORD(VERSION_WORD)) u_fcs_flash_ctrl_asserts (
  .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .nv_addr(nv_addr), .nv_rd(nv_rd), .nv_dbl_fault(nv_dbl_fault), .arr_rd_req(arr_rd_req),
  .arr_dbl_fault(arr_dbl_fault), .arr_stall(arr_stall), .arr_data_invalid(arr_data_invalid), .cmd_start(cmd_start));

// *** dv/fcs_nvm_model.sv ***
`timescale 1ns/10ps
module fcs_nvm_model #(
  parameter int DLY = 8
) (
  input wire logic mclk,
  input wire logic nv_rd,
  input wire logic [7:0] opt,
  output logic [7:0] nv_data,
  input wire logic cmd_start,
  output logic cmd_done
);
  int cnt = 0;
  // Byte valid only while read; inverted otherwise so a late sample shows
  assign nv_data = nv_rd ? opt : ~opt;
  // Executor finishes a fixed time after launch
  always_ff @(posedge mclk) begin
    cnt <= cmd_start ? DLY : (cnt > 0 ? cnt - 1 : 0);
    cmd_done <= (cnt == 1);
  end
endmodule

// *** dv/test_flash_cmd_object_and_timing.sv ***
`timescale 1ns/10ps
`include "fcs_defs.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_flash_cmd_object_and_timing;
  logic mclk, reset, special_mode, reg_wr, reg_rd, nv_rd, nv_dbl_fault, arr_rd_req, arr_dbl_fault;
  logic arr_stall, arr_data_invalid, cmd_start, cmd_is_prog, cmd_done;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, nv_data, cmd_code, opt;
  logic [23:0] nv_addr;
  int n_errors = 0;
  int checked = 0;
  fcs_flash_ctrl u_fcs_flash_ctrl (.mclk(mclk), .reset(reset), .special_mode(special_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nv_addr(nv_addr), .nv_rd(nv_rd),
    .nv_data(nv_data), .nv_dbl_fault(nv_dbl_fault), .arr_rd_req(arr_rd_req), .arr_dbl_fault(arr_dbl_fault),
    .arr_stall(arr_stall), .arr_data_invalid(arr_data_invalid), .cmd_start(cmd_start), .cmd_code(cmd_code),
    .cmd_is_prog(cmd_is_prog), .cmd_done(cmd_done));
  fcs_nvm_model u_fcs_nvm_model (.mclk(mclk), .nv_rd(nv_rd), .opt(opt), .nv_data(nv_data),
    .cmd_start(cmd_start), .cmd_done(cmd_done));
  // 10 MHz clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task give_verdict;
    $display("errors=%0d checks=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Strobes last one cycle; the next call waits an edge so none is driven twice in a step
  task wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata & m, e)
  endtask
  // Fault level must stand through the load cycle after release
  task rst(input logic f);
    reset <= 1'b1;
    nv_dbl_fault <= f;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    nv_dbl_fault <= 1'b0;
  endtask
  // Main sequence
  initial begin
    {reset, special_mode, reg_wr, reg_rd, arr_rd_req, arr_dbl_fault, nv_dbl_fault} = 7'h40;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    opt = 8'h3c;
    rst(1'b1);
    chk(`FCS_A_OPT, 8'hff, 8'hff);
    rst(1'b0);
    chk(`FCS_A_OPT, 8'hff, 8'h3c);
    @(posedge mclk);
    arr_rd_req <= 1'b1;
    #1 `CHK(arr_stall, 1'b1)
    @(posedge mclk);
    arr_rd_req <= 1'b0;
    wr(`FCS_A_OPT, 8'hc3);
    chk(`FCS_A_OPT, 8'hff, 8'h3c);
    wr(`FCS_A_RSV, 8'hff);
    chk(`FCS_A_RSV, 8'hff, 8'h00);
    chk(`FCS_A_VER, 8'h0f, 8'h05);
    for (int k = 0; k < 12; k++) wr(5'(k) + 5'h10, 8'(k) + 8'h40);
    for (int k = 0; k < 12; k++) chk(5'(k) + 5'h10, 8'hff, 8'(k) + 8'h40);
    wr(`FCS_A_OBJ, 8'h01);
    wr(`FCS_A_IX, 8'h00);
    wr(`FCS_A_STAT, 8'h80);
    #1 `CHK(cmd_start, 1'b1)
    `CHK(cmd_code, 8'h01)
    wr(`FCS_A_OBJ, 8'h55);
    chk(`FCS_A_STAT, 8'h80, 8'h00);
    repeat (12) @(posedge mclk);
    chk(`FCS_A_STAT, 8'h80, 8'h80);
    chk(`FCS_A_OBJ, 8'hff, 8'h01);
    // Program before any divider write is refused
    wr(`FCS_A_OBJ, 8'h06);
    wr(`FCS_A_STAT, 8'h80);
    #1 `CHK(cmd_start, 1'b0)
    chk(`FCS_A_STAT, 8'ha0, 8'ha0);
    wr(`FCS_A_STAT, 8'h20);
    chk(`FCS_A_STAT, 8'h20, 8'h00);
    wr(`FCS_A_DIV, 8'h85);
    chk(`FCS_A_PSTAT, 8'h80, 8'h80);
    wr(`FCS_A_DIV, 8'h07);
    chk(`FCS_A_DIV, 8'hff, 8'h85);
    wr(`FCS_A_STAT, 8'h80);
    #1 `CHK(cmd_start, 1'b1)
    repeat (12) @(posedge mclk);
    // Wait-states off, then fault tagging
    wr(`FCS_A_CFG, 8'h00);
    chk(`FCS_A_PSTAT, 8'h01, 8'h00);
    repeat (5) @(posedge mclk);
    chk(`FCS_A_PSTAT, 8'h01, 8'h01);
    @(posedge mclk);
    arr_rd_req <= 1'b1;
    arr_dbl_fault <= 1'b1;
    #1 `CHK(arr_data_invalid, 1'b1)
    @(posedge mclk);
    {arr_rd_req, arr_dbl_fault, special_mode} <= 3'h1;
    wr(`FCS_A_PSTAT, 8'h02);
    chk(`FCS_A_PSTAT, 8'h02, 8'h00);
    wr(`FCS_A_CFG, 8'h01);
    chk(`FCS_A_PSTAT, 8'h02, 8'h02);
    @(posedge mclk);
    arr_rd_req <= 1'b1;
    #1 `CHK(arr_data_invalid, 1'b0)
    @(posedge mclk);
    arr_rd_req <= 1'b0;
    wr(`FCS_A_CFG, 8'h03);
    repeat (5) @(posedge mclk);
    chk(`FCS_A_PSTAT, 8'h01, 8'h01);
    wr(`FCS_A_DIV, 8'h03);
    chk(`FCS_A_DIV, 8'h7f, 8'h03);
    give_verdict;
  end
  // Watchdog well beyond the fewer than two hundred cycles needed
  initial begin
    #200000;
    n_errors++;
    give_verdict;
  end
endmodule

// *** hw/fcs_defs.svh ***
`ifndef FCS_DEFS_SVH
`define FCS_DEFS_SVH
// Register indexes on the plain bus (address is an index, not a byte address)
`define FCS_A_DIV 5'h00
`define FCS_A_CFG 5'h01
`define FCS_A_IX 5'h02
`define FCS_A_STAT 5'h03
`define FCS_A_PSTAT 5'h04
`define FCS_A_OPT 5'h05
`define FCS_A_RSV 5'h06
`define FCS_A_VER 5'h07
`define FCS_A_OBJ 5'h10
`define FCS_A_OBJ_END 5'h1b
// Field positions
`define FCS_STAT_DONE 7
`define FCS_STAT_ACC_ERR 5
`define FCS_STAT_PVIOL 4
`define FCS_CFG_FORCE_FAULT 0
`define FCS_CFG_WS 1
`define FCS_PSTAT_WSACK 0
`define FCS_PSTAT_DBL_FAULT 1
`define FCS_DIV_LCK 7
`define FCS_DIV_LD 7
// Nonvolatile addresses
`define FCS_NV_OPT_ADDR 24'hfffe0e
`define FCS_VER_ADDR 24'h1fc0b6
// Reset values and counts
`define FCS_OPT_FAULT 8'hff
`define FCS_WS_SETTLE 3'h3
`define FCS_EXEC_CYCLES 8'h10
`endif

// *** hw/fcs_flash_ctrl.sv ***
`timescale 1ns/10ps
`include "fcs_defs.svh"
module fcs_flash_ctrl #(
  parameter int OBJ_WORDS = 6,
  parameter logic [15:0] VERSION_WORD = 16'h0005 // Arbitrary version value
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic special_mode,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [23:0] nv_addr,
  output logic nv_rd,
  input wire logic [7:0] nv_data,
  input wire logic nv_dbl_fault,
  input wire logic arr_rd_req,
  input wire logic arr_dbl_fault,
  output logic arr_stall,
  output logic arr_data_invalid,
  output logic cmd_start,
  output logic [7:0] cmd_code,
  output logic cmd_is_prog,
  input wire logic cmd_done
);
  // Sequencer and register state
  fcs_pkg::fcs_state_t state_reg;
  logic [7:0] opt_reg;
  logic [7:0] cmd_obj_reg [2*OBJ_WORDS];
  logic [2:0] ix_reg;
  logic [6:0] div_reg;
  logic div_lock_reg;
  logic div_ld_reg;
  logic force_fault_reg;
  logic ws_reg;
  logic ws_eff_reg;
  logic [2:0] ws_cnt_reg;
  logic access_err_reg;
  logic pviol_reg;
  logic dbl_fault_flag_reg;
  logic [7:0] exec_cnt_reg;
  // Decode and handshake helpers
  logic [7:0] rdata_next;
  logic wr_stat;
  logic launch;
  logic [4:0] obj_idx;
  logic prog_like;
  logic stall_reg;
  logic nv_fault_s1_reg;
  logic nv_fault_reg;
  logic launch_ok;
  logic exec_over;
  logic div_wr_ok;

  // Register map, one byte per index
  //   0x00 divider: [7] lock, [6:0] divider value
  //   0x01 config: [1] wait-state enable, [0] force double fault
  //   0x02 index: [2:0] command object words loaded
  //   0x03 status: [7] command complete, [5] access error, [4] protection violation
  //   0x04 protection status: [7] divider loaded, [1] double fault, [0] wait acknowledge
  //   0x05 option byte, read only
  //   0x06 factory reserved, reads zero
  //   0x07 version, low nibble only
  //   0x10-0x1b command object array, even index is the high byte
  // Write behaviour
  //   Status bit 7 written one launches; bits 5 and 4 written one clear
  //   Protection status bit 1 written one clears the double fault flag
  //   Option, reserved and version indexes drop every write
  //   Array, index and divider writes are dropped while a command runs
  //   Divider writes are dropped once locked, unless in special mode
  //   Force-fault bit only sticks in special mode
  // Read behaviour
  //   Data stands in the cycle after the read strobe and is zero otherwise
  //   Unmapped indexes read zero, so software probing sees no garbage
  // Sequencing
  //   Load: one cycle after reset release, option byte captured
  //   Idle: command complete reads one, array open to software
  //   Exec: array locked, completion on back-end done or timeout
  //   The timeout keeps a dead back end from hanging software forever
  // Timing
  //   Writes take effect at the edge that samples the strobe
  //   Launch write at edge n gives the start pulse after edge n
  //   Start pulse lasts exactly one cycle
  //   Wait acknowledge drops for a few cycles after a wait-state change
  //   Array read stall lasts one cycle per read while wait-states apply
  //   Invalid tag is combinational, valid only in the unstalled read cycle
  // Limitations
  //   Protection violation is only ever cleared here; its set source is outside
  //   Index register is stored for software only; sequencing does not read it
  //   Wait-state change waits a fixed settle count rather than for reads to drain
  //   Version word upper bits are reserved and read as zero

  // Program and erase codes all need the divider; verify and read do not
  function automatic logic is_prog_erase(input logic [7:0] code);
    case (code)
      8'h06: is_prog_erase = 1'b1; // Program array
      8'h07: is_prog_erase = 1'b1; // Program once field
      8'h08: is_prog_erase = 1'b1; // Erase all blocks
      8'h09: is_prog_erase = 1'b1; // Erase one block
      8'h0a: is_prog_erase = 1'b1; // Erase one sector
      8'h0b: is_prog_erase = 1'b1; // Unsecure, erases everything
      8'h11: is_prog_erase = 1'b1; // Program data area
      8'h12: is_prog_erase = 1'b1; // Erase data area sector
      default: is_prog_erase = 1'b0;
    endcase
  endfunction

  // Address falls inside the command object window; shared by write and read paths
  function automatic logic in_obj_range(input logic [4:0] addr);
    in_obj_range = addr >= `FCS_A_OBJ && addr <= `FCS_A_OBJ_END;
  endfunction

  assign obj_idx = reg_addr - `FCS_A_OBJ;
  assign wr_stat = reg_wr && reg_addr == `FCS_A_STAT;
  assign launch = wr_stat && reg_wdata[`FCS_STAT_DONE] && state_reg == fcs_pkg::FCS_IDLE;
  assign prog_like = is_prog_erase(cmd_obj_reg[0]);
  assign cmd_code = cmd_obj_reg[0];
  assign nv_addr = `FCS_NV_OPT_ADDR;
  assign nv_rd = state_reg == fcs_pkg::FCS_LOAD;

  // A program or erase launched without a loaded divider is refused
  assign launch_ok = launch && !(prog_like && !div_ld_reg);

  // Sequencer: option load after reset, then idle and execute
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg <= fcs_pkg::FCS_LOAD;
    end else begin
      case (state_reg)
        fcs_pkg::FCS_LOAD: begin
          state_reg <= fcs_pkg::FCS_IDLE;
        end
        fcs_pkg::FCS_IDLE: begin
          if (launch_ok) begin
            state_reg <= fcs_pkg::FCS_EXEC;
          end
        end
        fcs_pkg::FCS_EXEC: begin
          // Back end may finish early; otherwise a fixed timeout completes
          if (exec_over) begin
            state_reg <= fcs_pkg::FCS_IDLE;
          end
        end
        default: begin
          state_reg <= fcs_pkg::FCS_IDLE;
        end
      endcase
    end
  end

  // Completion comes from the back end or from the timeout
  assign exec_over = cmd_done || exec_cnt_reg == 8'h00;

  // Start pulse is registered so the back end sees one clean cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_start <= 1'b0;
    end else begin
      cmd_start <= launch_ok;
    end
  end

  // Program flag follows the accepted command and holds through execution
  always_ff @(posedge mclk) begin
    if (reset) begin
      cmd_is_prog <= 1'b0;
    end else if (launch_ok) begin
      cmd_is_prog <= prog_like;
    end
  end

  // Timeout counter: loaded at launch, counts down while executing
  always_ff @(posedge mclk) begin
    if (reset) begin
      exec_cnt_reg <= 8'h00;
    end else if (launch_ok) begin
      exec_cnt_reg <= `FCS_EXEC_CYCLES;
    end else if (state_reg == fcs_pkg::FCS_EXEC && !exec_over) begin
      exec_cnt_reg <= exec_cnt_reg - 8'h01;
    end
  end

  // Fault pin is async: two flops, running through reset so the level reaches the load cycle
  always_ff @(posedge mclk) begin
    nv_fault_s1_reg <= nv_dbl_fault;
    nv_fault_reg <= nv_fault_s1_reg;
  end

  // Loaded once per reset; no write path exists
  always_ff @(posedge mclk) begin
    if (reset) begin
      opt_reg <= `FCS_OPT_FAULT;
    end else if (state_reg == fcs_pkg::FCS_LOAD) begin
      opt_reg <= nv_fault_reg ? `FCS_OPT_FAULT : nv_data;
    end
  end

  // Command object array, byte addressed, high byte at even index
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int i = 0; i < 2*OBJ_WORDS; i++) begin
        cmd_obj_reg[i] <= 8'h00;
      end
    end else if (reg_wr && state_reg == fcs_pkg::FCS_IDLE && in_obj_range(reg_addr)) begin
      cmd_obj_reg[obj_idx[3:0]] <= reg_wdata;
    end
  end

  // Index register steered by software
  always_ff @(posedge mclk) begin
    if (reset) begin
      ix_reg <= 3'h0;
    end else if (reg_wr && reg_addr == `FCS_A_IX && state_reg == fcs_pkg::FCS_IDLE) begin
      ix_reg <= reg_wdata[2:0];
    end
  end

  // Divider write accepted when idle and unlocked; special mode ignores the lock
  assign div_wr_ok = reg_wr && reg_addr == `FCS_A_DIV && state_reg == fcs_pkg::FCS_IDLE
                     && (!div_lock_reg || special_mode);

  // Divider value and lock; a set lock holds until reset, except that a special-mode write can clear it
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_reg <= 7'h00;
      div_lock_reg <= 1'b0;
    end else if (div_wr_ok) begin
      div_reg <= reg_wdata[6:0];
      div_lock_reg <= reg_wdata[`FCS_DIV_LCK];
    end
  end

  // Loaded flag: set by any accepted divider write, cleared only by reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      div_ld_reg <= 1'b0;
    end else if (div_wr_ok) begin
      div_ld_reg <= 1'b1;
    end
  end

  // Wait-state enable; maximum wait-states out of reset
  always_ff @(posedge mclk) begin
    if (reset) begin
      ws_reg <= 1'b1;
    end else if (reg_wr && reg_addr == `FCS_A_CFG) begin
      ws_reg <= reg_wdata[`FCS_CFG_WS];
    end
  end

  // Force-fault bit only sticks in special mode
  always_ff @(posedge mclk) begin
    if (reset) begin
      force_fault_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `FCS_A_CFG) begin
      force_fault_reg <= reg_wdata[`FCS_CFG_FORCE_FAULT] & special_mode;
    end
  end

  // Settle counter runs while requested and effective settings differ
  always_ff @(posedge mclk) begin
    if (reset) begin
      ws_cnt_reg <= 3'h0;
    end else if (ws_reg != ws_eff_reg && ws_cnt_reg != `FCS_WS_SETTLE) begin
      ws_cnt_reg <= ws_cnt_reg + 3'h1;
    end else begin
      ws_cnt_reg <= 3'h0;
    end
  end

  // New wait setting applies only after the fixed settle count
  always_ff @(posedge mclk) begin
    if (reset) begin
      ws_eff_reg <= 1'b1;
    end else if (ws_reg != ws_eff_reg && ws_cnt_reg == `FCS_WS_SETTLE) begin
      ws_eff_reg <= ws_reg;
    end
  end

  // One wait cycle per array read when wait-states are effective
  always_ff @(posedge mclk) begin
    if (reset) begin
      stall_reg <= 1'b0;
    end else begin
      stall_reg <= arr_rd_req && ws_eff_reg && !stall_reg;
    end
  end
  assign arr_stall = arr_rd_req && ws_eff_reg && !stall_reg;
  assign arr_data_invalid = arr_rd_req && !arr_stall && arr_dbl_fault;

  // Access error: a refused program launch sets it; set wins over a clear in one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      access_err_reg <= 1'b0;
    end else if (launch && prog_like && !div_ld_reg) begin
      access_err_reg <= 1'b1;
    end else if (wr_stat && reg_wdata[`FCS_STAT_ACC_ERR]) begin
      access_err_reg <= 1'b0;
    end
  end

  // Protection violation: set source lies outside this block, software clear only
  always_ff @(posedge mclk) begin
    if (reset) begin
      pviol_reg <= 1'b0;
    end else if (wr_stat && reg_wdata[`FCS_STAT_PVIOL]) begin
      pviol_reg <= 1'b0;
    end
  end

  // Double fault flag: array fault or forced fault sets it, set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      dbl_fault_flag_reg <= 1'b0;
    end else if ((arr_rd_req && !arr_stall && arr_dbl_fault) || force_fault_reg) begin
      dbl_fault_flag_reg <= 1'b1;
    end else if (reg_wr && reg_addr == `FCS_A_PSTAT && reg_wdata[`FCS_PSTAT_DBL_FAULT]) begin
      dbl_fault_flag_reg <= 1'b0;
    end
  end

  // Read mux; unmapped and reserved addresses return zero
  always_comb begin
    rdata_next = 8'h00;
    if (in_obj_range(reg_addr)) begin
      rdata_next = cmd_obj_reg[obj_idx[3:0]];
    end else begin
      case (reg_addr)
        `FCS_A_DIV: rdata_next = {div_lock_reg, div_reg};
        `FCS_A_CFG: rdata_next = {6'h00, ws_reg, force_fault_reg};
        `FCS_A_IX: rdata_next = {5'h00, ix_reg};
        `FCS_A_STAT: rdata_next = {state_reg == fcs_pkg::FCS_IDLE, 1'b0, access_err_reg, pviol_reg, 4'h0};
        `FCS_A_PSTAT: rdata_next = {div_ld_reg, 5'h00, dbl_fault_flag_reg, ws_reg == ws_eff_reg};
        `FCS_A_OPT: rdata_next = opt_reg;
        `FCS_A_RSV: rdata_next = 8'h00;
        `FCS_A_VER: rdata_next = {4'h0, VERSION_WORD[3:0]};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 8'h00;
    end
  end
endmodule

// *** hw/fcs_pkg.sv ***
package fcs_pkg;
  typedef enum logic [1:0] {FCS_LOAD, FCS_IDLE, FCS_EXEC} fcs_state_t;
endpackage
